// *** hw/tx_cmd_a_fields.sv ***
// Field decoder for one transmit command A word, with the padding arithmetic.
`timescale 1ns/1ps
module tx_cmd_a_fields (
   input wire logic [31:0] cmd_a_i,
   output logic interrupt_req_o,
   output logic first_seg_o,
   output logic last_seg_o,
   output logic rsvd_err_o,
   output logic align_err_o,
   output logic [4:0] offset_o,
   output logic [10:0] size_o,
   output logic [9:0] data_words_o,
   output logic [9:0] padded_words_o
);

   logic [1:0] align_code;
   logic [9:0] align_mask;
   logic [11:0] span;
   logic [11:0] span_up;

   // Plain field extraction.
   assign interrupt_req_o = cmd_a_i[tx_cmd_a_pkg::IOC_BIT];
   assign first_seg_o = cmd_a_i[tx_cmd_a_pkg::FIRST_SEG_BIT];
   assign last_seg_o = cmd_a_i[tx_cmd_a_pkg::LAST_SEG_BIT];
   assign offset_o = cmd_a_i[tx_cmd_a_pkg::OFFSET_HI:tx_cmd_a_pkg::OFFSET_LO];
   assign size_o = cmd_a_i[tx_cmd_a_pkg::SIZE_HI:0];
   assign rsvd_err_o = |(cmd_a_i & tx_cmd_a_pkg::CMD_A_RSVD_MASK);
   assign align_code = cmd_a_i[tx_cmd_a_pkg::ALIGN_HI:tx_cmd_a_pkg::ALIGN_LO];

   // End alignment; the reserved code is flagged and treated as 4-byte.
   assign align_mask = (align_code == tx_cmd_a_pkg::ALIGN_16_CODE) ? tx_cmd_a_pkg::ALIGN_16_MASK :
                       (align_code == tx_cmd_a_pkg::ALIGN_32_CODE) ? tx_cmd_a_pkg::ALIGN_32_MASK :
                       tx_cmd_a_pkg::ALIGN_4_MASK;
   assign align_err_o = (align_code != tx_cmd_a_pkg::ALIGN_4_CODE) && (align_code != tx_cmd_a_pkg::ALIGN_16_CODE)
                        && (align_code != tx_cmd_a_pkg::ALIGN_32_CODE);

   // Words holding offset and payload, then rounded up to the alignment.
   assign span = {7'h00, offset_o} + {1'b0, size_o};
   assign span_up = span + 12'h003;
   assign data_words_o = span_up[11:2];
   assign padded_words_o = (data_words_o + align_mask) & ~align_mask;

endmodule : tx_cmd_a_fields

// *** hw/tx_cmd_a_pkg.sv ***
// Package with offsets, field positions and reset values of the transmit command A decoder.
package tx_cmd_a_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [4:0] STATUS_OFS = 5'h00;
   localparam logic [4:0] MASK_OFS = 5'h04;
   localparam logic [4:0] CONTROL_OFS = 5'h08;
   localparam logic [4:0] CMD_A_OFS = 5'h0c;
   localparam logic [4:0] PKT_BYTES_OFS = 5'h10;

   // Status and mask bit positions.
   localparam int STATUS_W = 4;
   localparam int ST_LOADED_BIT = 0;
   localparam int ST_TX_ERR_BIT = 1;
   localparam int ST_RSVD_BIT = 2;
   localparam int ST_ALIGN_BIT = 3;
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // Control bit positions and reset value.
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_CHECK_RSVD_BIT = 1;
   localparam logic [1:0] CONTROL_RESET = 2'h3;

   // Command A field layout.
   localparam int IOC_BIT = 31;
   localparam logic [31:0] CMD_A_RSVD_MASK = 32'h7c00c000;
   localparam int ALIGN_HI = 25;
   localparam int ALIGN_LO = 24;
   localparam int OFFSET_HI = 20;
   localparam int OFFSET_LO = 16;
   localparam int FIRST_SEG_BIT = 13;
   localparam int LAST_SEG_BIT = 12;
   localparam int SIZE_HI = 10;

   // Command B packet length field.
   localparam int PKT_LEN_HI = 10;

   // End alignment codes and the word masks they round to.
   localparam logic [1:0] ALIGN_4_CODE = 2'h0;
   localparam logic [1:0] ALIGN_16_CODE = 2'h1;
   localparam logic [1:0] ALIGN_32_CODE = 2'h2;
   localparam logic [9:0] ALIGN_4_MASK = 10'h000;
   localparam logic [9:0] ALIGN_16_MASK = 10'h003;
   localparam logic [9:0] ALIGN_32_MASK = 10'h007;

endpackage : tx_cmd_a_pkg

// *** hw/tx_command_a_decoder.sv ***
// Transmit command A decoder: parses command words, strips offset and padding, checks packets.
// Overview of operation
// - Raise buffer-loaded flag when requested buffer finishes.
// - Decode end alignment: 4, 16, 32 bytes.
// - Drop host padding words, never forward them.
// - Start offset locates first payload byte; skip earlier.
// - First-segment bit opens a new packet.
// - Low eleven bits give buffer byte count.
// - Sum segment sizes; mismatch sets transmit error.
// - Offset low bits pick first valid lane.
// - Offset high bits skip up to seven words.
`timescale 1ns/1ps
module tx_command_a_decoder (
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire logic [31:0] WORD_I,
   input wire logic WORD_VALID_I,
   output logic [31:0] DATA_O,
   output logic [3:0] BYTE_EN_O,
   output logic DATA_VALID_O,
   output logic PACKET_START_O,
   output logic PACKET_END_O,
   output logic BUFFER_LOADED_FLAG_O,
   output logic TRANSMIT_ERROR_FLAG_O,
   output logic IRQ_O,
   input wire logic [4:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O
);

   // Parser position within one buffer.
   typedef enum logic [1:0] {WAIT_CMD_A, WAIT_CMD_B, PASS_DATA} parse_e;

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.

   parse_e state;
   logic [31:0] cmd_a;
   logic [31:0] cmd_b;
   logic packet_open;
   logic [11:0] accum;
   logic [9:0] word_idx;
   logic sent_any;
   logic [3:0] status;
   logic [3:0] mask;
   logic [1:0] control;
   logic bus_ack;

   // Fields of the held command A word.
   logic ioc;
   logic first_seg;
   logic last_seg;
   logic rsvd_err;
   logic align_err;
   logic [4:0] offset;
   logic [10:0] size;
   logic [9:0] data_words;
   logic [9:0] padded_words;

   ////////////////////////////////////////////////////////////////////////////////
   // Field decode of the held command A word.

   tx_cmd_a_fields u_fields (
      .cmd_a_i(cmd_a),
      .interrupt_req_o(ioc),
      .first_seg_o(first_seg),
      .last_seg_o(last_seg),
      .rsvd_err_o(rsvd_err),
      .align_err_o(align_err),
      .offset_o(offset),
      .size_o(size),
      .data_words_o(data_words),
      .padded_words_o(padded_words)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Word intake and buffer sequencing terms.

   // Words are dropped while disabled; the parser keeps its place.
   wire logic take = WORD_VALID_I & control[tx_cmd_a_pkg::CTRL_ENABLE_BIT];
   wire logic at_cmd_a = take & (state == WAIT_CMD_A);
   wire logic at_cmd_b = take & (state == WAIT_CMD_B);
   wire logic at_data = take & (state == PASS_DATA);
   wire logic is_last_word = (word_idx == (padded_words - 10'h001));
   wire logic empty_buffer = (padded_words == 10'h000);
   wire logic buffer_done = (at_data & is_last_word) | (at_cmd_b & empty_buffer);

   // Byte window of the payload inside the data section.
   wire logic [11:0] first_pos = {7'h00, offset};
   wire logic [11:0] end_pos = first_pos + {1'b0, size};
   logic [3:0] lane_ok;

   // Per-lane validity: bytes before the offset and past the count are dropped.
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
         wire logic [11:0] pos = {word_idx, 2'(lane)};
         assign lane_ok[lane] = at_data && (pos >= first_pos) && (pos < end_pos);
      end
   endgenerate

   wire logic any_ok = |lane_ok;
   wire logic payload_last = (word_idx == (data_words - 10'h001));

   ////////////////////////////////////////////////////////////////////////////////
   // Packet bookkeeping terms.

   // The running count restarts on a first segment; command B must repeat unchanged.
   wire logic [11:0] sum_accum = first_seg ? {1'b0, size} : (accum + {1'b0, size});
   wire logic [11:0] eff_accum = at_cmd_b ? sum_accum : accum;
   wire logic [31:0] eff_cmd_b = (at_cmd_b & first_seg) ? WORD_I : cmd_b;
   wire logic [11:0] eff_len = {1'b0, eff_cmd_b[tx_cmd_a_pkg::PKT_LEN_HI:0]};
   wire logic seq_err = at_cmd_b & (first_seg ? packet_open : (~packet_open | (WORD_I != cmd_b)));
   wire logic len_err = buffer_done & last_seg & (eff_accum != eff_len);

   // Events that set sticky status bits.
   wire logic loaded_ev = buffer_done & ioc;
   wire logic tx_err_ev = seq_err | len_err;
   wire logic rsvd_ev = at_cmd_b & rsvd_err & control[tx_cmd_a_pkg::CTRL_CHECK_RSVD_BIT];
   wire logic align_ev = at_cmd_b & align_err;
   logic [3:0] status_set;

   // Gather the events into the status layout.
   always_comb begin
      status_set = 4'h0;
      status_set[tx_cmd_a_pkg::ST_LOADED_BIT] = loaded_ev;
      status_set[tx_cmd_a_pkg::ST_TX_ERR_BIT] = tx_err_ev;
      status_set[tx_cmd_a_pkg::ST_RSVD_BIT] = rsvd_ev;
      status_set[tx_cmd_a_pkg::ST_ALIGN_BIT] = align_ev;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Parser state machine.

   // Steps command A, command B and the data words of each buffer.
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         state <= WAIT_CMD_A;
      end else begin
         unique case (state)
            WAIT_CMD_A: begin
               if (at_cmd_a) begin
                  state <= WAIT_CMD_B;
               end
            end
            WAIT_CMD_B: begin
               if (at_cmd_b) begin
                  state <= empty_buffer ? WAIT_CMD_A : PASS_DATA;
               end
            end
            PASS_DATA: begin
               if (buffer_done) begin
                  state <= WAIT_CMD_A;
               end
            end
         endcase
      end
   end

   // Command capture and data word index within the buffer.
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         cmd_a <= 32'h0000_0000;
         word_idx <= 10'h000;
         sent_any <= 1'b0;
      end else begin
         if (at_cmd_a) begin
            cmd_a <= WORD_I;
         end
         if (at_cmd_b) begin
            word_idx <= 10'h000;
            sent_any <= 1'b0;
         end else if (at_data) begin
            word_idx <= word_idx + 10'h001;
            sent_any <= sent_any | any_ok;
         end
      end
   end

   // Packet open flag, reference command B and running byte count.
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         packet_open <= 1'b0;
         cmd_b <= 32'h0000_0000;
         accum <= 12'h000;
      end else begin
         if (at_cmd_b) begin
            accum <= sum_accum;
            cmd_b <= eff_cmd_b;
            if (first_seg) begin
               packet_open <= 1'b1;
            end
         end
         if (buffer_done & last_seg) begin
            packet_open <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Payload output.

   // Registered payload words with lane enables and packet markers.
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         DATA_O <= 32'h0000_0000;
         BYTE_EN_O <= 4'h0;
         DATA_VALID_O <= 1'b0;
         PACKET_START_O <= 1'b0;
         PACKET_END_O <= 1'b0;
      end else begin
         if (at_data) begin
            DATA_O <= WORD_I;
         end
         BYTE_EN_O <= lane_ok;
         DATA_VALID_O <= any_ok;
         PACKET_START_O <= any_ok & first_seg & ~sent_any;
         PACKET_END_O <= any_ok & last_seg & payload_last;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave.

   // Address decode and write strobes; writes land on the completing edge.
   wire logic bus_req = AVS_READ_I | AVS_WRITE_I;
   wire logic [4:0] word_addr = {AVS_ADDRESS_I[4:2], 2'h0};
   wire logic sel_status = (word_addr == tx_cmd_a_pkg::STATUS_OFS);
   wire logic sel_mask = (word_addr == tx_cmd_a_pkg::MASK_OFS);
   wire logic sel_control = (word_addr == tx_cmd_a_pkg::CONTROL_OFS);
   wire logic sel_cmd_a = (word_addr == tx_cmd_a_pkg::CMD_A_OFS);
   wire logic sel_bytes = (word_addr == tx_cmd_a_pkg::PKT_BYTES_OFS);
   wire logic wr_mask = bus_ack & AVS_WRITE_I & sel_mask & AVS_BYTEENABLE_I[0];
   wire logic wr_control = bus_ack & AVS_WRITE_I & sel_control & AVS_BYTEENABLE_I[0];
   wire logic rd_clear = bus_ack & AVS_READ_I & sel_status;

   // Read selection; unmapped offsets read as zero.
   wire logic [31:0] read_mux = sel_status ? {28'h0000000, status} :
                                sel_mask ? {28'h0000000, mask} :
                                sel_control ? {30'h0, control} :
                                sel_cmd_a ? cmd_a :
                                sel_bytes ? {20'h00000, accum} :
                                32'h0000_0000;

   // The answer comes one cycle after the request is seen.
   assign AVS_WAITREQUEST_O = bus_req & ~bus_ack;

   // Acknowledge and read data capture.
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         bus_ack <= 1'b0;
         AVS_READDATA_O <= 32'h0000_0000;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
         if (AVS_READ_I & ~bus_ack) begin
            AVS_READDATA_O <= read_mux;
         end
      end
   end

   // Mask and control writes take effect on the accepting edge.
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         mask <= tx_cmd_a_pkg::MASK_RESET;
         control <= tx_cmd_a_pkg::CONTROL_RESET;
      end else begin
         if (wr_mask) begin
            mask <= AVS_WRITEDATA_I[3:0];
         end
         if (wr_control) begin
            control <= AVS_WRITEDATA_I[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status and interrupt.

   // Read clears the status; a new event in the same cycle survives the clear.
   wire logic [3:0] next_status = (rd_clear ? 4'h0 : status) | status_set;

   // Sticky status register.
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         status <= tx_cmd_a_pkg::STATUS_RESET;
      end else begin
         status <= next_status;
      end
   end

   // Flags and the level interrupt follow the status register.
   assign BUFFER_LOADED_FLAG_O = status[tx_cmd_a_pkg::ST_LOADED_BIT];
   assign TRANSMIT_ERROR_FLAG_O = status[tx_cmd_a_pkg::ST_TX_ERR_BIT];
   assign IRQ_O = |(status & mask);

endmodule : tx_command_a_decoder

// *** sim/host_fifo_writer.sv ***
// Host model that writes command words and padded payload into the word stream.
`timescale 1ns/1ps
module host_fifo_writer (
   input wire logic clk_i,
   output logic [31:0] word_o,
   output logic valid_o
);
   initial begin
      word_o = 32'h0;
      valid_o = 1'b0;
   end
   // Writes command A, command B, then whole payload words padded to the end alignment.
   task automatic send_buffer(input logic [31:0] cmd_a, input logic [31:0] cmd_b);
      int n;
      int blk;
      n = (int'(cmd_a[20:16]) + int'(cmd_a[10:0]) + 3) / 4;
      blk = (cmd_a[25:24] == 2'h1) ? 4 : ((cmd_a[25:24] == 2'h2) ? 8 : 1);
      n = (n + blk - 1) / blk * blk;
      for (int k = -2; k < n; k++) begin
         @(posedge clk_i);
         word_o <= (k == -2) ? cmd_a : ((k == -1) ? cmd_b : 32'hc0de0000 + 32'(k));
         valid_o <= 1'b1;
      end
      @(posedge clk_i);
      valid_o <= 1'b0;
      word_o <= ~word_o;
   endtask : send_buffer
endmodule : host_fifo_writer

// *** sim/tx_cmd_a_checker.sv ***
// Port checker of the transmit command A decoder.
`timescale 1ns/1ps
module tx_cmd_a_checker (
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire logic WORD_VALID_I,
   input wire logic [3:0] BYTE_EN_O,
   input wire logic DATA_VALID_O,
   input wire logic PACKET_START_O,
   input wire logic PACKET_END_O,
   input wire logic BUFFER_LOADED_FLAG_O,
   input wire logic TRANSMIT_ERROR_FLAG_O,
   input wire logic [4:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WAITREQUEST_O
);
   // A status read completes here, which is the only thing that may clear a flag.
   wire stat_rd = AVS_READ_I && !AVS_WAITREQUEST_O && (AVS_ADDRESS_I[4:2] == 3'h0);
   default clocking @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RESETN_I);
   ////////////////////////////////////////////////////////////////////////////////
   a_start_has_data: assert property (PACKET_START_O |-> DATA_VALID_O)
      else $error("packet start without payload beat");
   a_end_has_data: assert property (PACKET_END_O |-> DATA_VALID_O)
      else $error("packet end without payload beat");
   a_lanes_contig: assert property (DATA_VALID_O |-> BYTE_EN_O inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6,
      4'h7, 4'h8, 4'hc, 4'he, 4'hf}) else $error("byte lanes not contiguous");
   a_beat_from_word: assert property (DATA_VALID_O |-> $past(WORD_VALID_I))
      else $error("payload beat without a taken word");
   a_loaded_sticky: assert property (BUFFER_LOADED_FLAG_O && !stat_rd |=> BUFFER_LOADED_FLAG_O)
      else $error("loaded flag dropped without status read");
   a_loaded_cause: assert property ($rose(BUFFER_LOADED_FLAG_O) |-> $past(WORD_VALID_I))
      else $error("loaded flag rose without a taken word");
   a_err_sticky: assert property (TRANSMIT_ERROR_FLAG_O && !stat_rd |=> TRANSMIT_ERROR_FLAG_O)
      else $error("error flag dropped without status read");
   a_err_cause: assert property ($rose(TRANSMIT_ERROR_FLAG_O) |-> $past(WORD_VALID_I))
      else $error("error flag rose without a taken word");
   a_bus_answer: assert property (AVS_READ_I && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("read not answered in one cycle");
   // Main scenarios seen.
   cover property (PACKET_START_O && PACKET_END_O);
   cover property ($rose(TRANSMIT_ERROR_FLAG_O));
   cover property ($rose(BUFFER_LOADED_FLAG_O));
endmodule : tx_cmd_a_checker

// *** sim/tx_command_a_decoder_tb.sv ***
// Self-checking bench of the transmit command A decoder.
`timescale 1ns/1ps
module tx_command_a_decoder_tb;
   logic clk, rst_n, word_valid, dv, pstart, pend, loaded, txerr, irq, rd, wr, waitreq;
   logic [31:0] word, data, wdata, rdata;
   logic [3:0] be;
   logic [4:0] addr;
   logic [37:0] q[$];
   int n_fail = 0;
   int n_checks = 0;
   tx_command_a_decoder u_tx_command_a_decoder (.REF_CLK_I(clk), .RESETN_I(rst_n), .WORD_I(word),
      .WORD_VALID_I(word_valid), .DATA_O(data), .BYTE_EN_O(be), .DATA_VALID_O(dv), .PACKET_START_O(pstart),
      .PACKET_END_O(pend), .BUFFER_LOADED_FLAG_O(loaded), .TRANSMIT_ERROR_FLAG_O(txerr), .IRQ_O(irq),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq));
   host_fifo_writer u_host (.clk_i(clk), .word_o(word), .valid_o(word_valid));
   // Clock at 20 MHz.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Collects every payload beat with its markers.
   always @(posedge clk) begin
      if (dv === 1'b1) begin
         q.push_back({pstart, pend, be, data});
      end
   end
   task automatic close_out();
      $display("Checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One Avalon access, held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
      int t;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      for (t = 0; t < 50; t++) begin
         @(posedge clk);
         if (waitreq === 1'b0) break;
      end
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (t == 50) begin
         n_fail++;
         close_out();
      end
   endtask : bus
   task automatic read_chk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(r, exp);
   endtask : read_chk
   // Lanes of word w that fall inside the payload bytes [off, e).
   function automatic logic [3:0] lanes(input int off, input int e, input int w);
      logic [3:0] m;
      for (int i = 0; i < 4; i++) begin
         m[i] = (w * 4 + i >= off) && (w * 4 + i < e);
      end
      return m;
   endfunction : lanes
   // Sends one buffer and compares every beat with what offset, size and markers call for.
   task automatic run_buf(input logic [31:0] ca, input logic [31:0] cb);
      int off;
      int e;
      logic [37:0] g;
      logic [31:0] m;
      off = int'(ca[20:16]);
      e = off + int'(ca[10:0]);
      q.delete();
      u_host.send_buffer(ca, cb);
      repeat (2) @(posedge clk);
      check(32'(q.size()), 32'((e + 3) / 4 - off / 4));
      for (int w = off / 4; w < (e + 3) / 4 && q.size() > 0; w++) begin
         g = q.pop_front();
         m = {{8{lanes(off, e, w)}}};
         m = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
         check(32'(g[35:32]), 32'(lanes(off, e, w)));
         check(g[31:0] & m, (32'hc0de0000 + 32'(w)) & m);
         check(32'(g[37]), 32'(ca[13] && w == off / 4));
         check(32'(g[36]), 32'(ca[12] && w == (e + 3) / 4 - 1));
      end
   endtask : run_buf
   // Main sequence.
   initial begin
      int off, sz, al;
      logic [31:0] r;
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 5'h0;
      wdata = 32'h0;
      r = $urandom(1080);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h0);
      read_chk(tx_cmd_a_pkg::MASK_OFS, 32'h0);
      read_chk(tx_cmd_a_pkg::CONTROL_OFS, 32'h3);
      read_chk(5'h14, 32'h0);
      $display("Test reset values done");
      bus(1'b1, tx_cmd_a_pkg::MASK_OFS, 32'h1, r);
      for (int i = 0; i < 8; i++) begin
         off = (i == 0) ? 31 : ((i == 1) ? 0 : $urandom_range(31, 0));
         sz = (i == 0) ? 1 : ((i == 1) ? 4 : $urandom_range(40, 1));
         al = (i == 0) ? 2 : ((i == 1) ? 1 : $urandom_range(2, 0));
         run_buf({1'b1, 5'h0, 2'(al), 3'h0, 5'(off), 4'h3, 1'b0, 11'(sz)}, {16'(i), 5'h0, 11'(sz)});
         check(32'(irq), 32'h1);
         check(32'(loaded), 32'h1);
         read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h1);
         @(posedge clk);
         check(32'(irq), 32'h0);
      end
      $display("Test random buffers done");
      run_buf(32'h0101_2005, 32'h0000_000c);
      run_buf(32'h8002_1007, 32'h0000_000c);
      read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h1);
      run_buf(32'h0101_2005, 32'h0000_000d);
      run_buf(32'h8002_1007, 32'h0000_000d);
      check(32'(txerr), 32'h1);
      read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h3);
      u_host.send_buffer(32'h0000_1004, 32'h0000_0004);
      repeat (2) @(posedge clk);
      read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h2);
      $display("Test segmented packets done");
      u_host.send_buffer(32'h0400_3004, 32'h0000_0004);
      repeat (2) @(posedge clk);
      read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h4);
      u_host.send_buffer(32'h0300_3004, 32'h0000_0004);
      repeat (2) @(posedge clk);
      read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h8);
      $display("Test reserved codes done");
      read_chk(tx_cmd_a_pkg::CMD_A_OFS, 32'h0300_3004);
      read_chk(tx_cmd_a_pkg::PKT_BYTES_OFS, 32'h4);
      bus(1'b1, tx_cmd_a_pkg::CONTROL_OFS, 32'h1, r);
      u_host.send_buffer(32'h0400_3004, 32'h0000_0004);
      repeat (2) @(posedge clk);
      read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h0);
      bus(1'b1, tx_cmd_a_pkg::CONTROL_OFS, 32'h0, r);
      q.delete();
      u_host.send_buffer(32'h8000_3004, 32'h0000_0004);
      repeat (2) @(posedge clk);
      check(32'(q.size()), 32'h0);
      check(32'(loaded), 32'h0);
      bus(1'b1, tx_cmd_a_pkg::CONTROL_OFS, 32'h3, r);
      run_buf(32'h0000_3004, 32'h0000_0004);
      read_chk(tx_cmd_a_pkg::STATUS_OFS, 32'h0);
      $display("Test register controls done");
      close_out();
   end
endmodule : tx_command_a_decoder_tb
bind tx_command_a_decoder tx_cmd_a_checker u_tx_cmd_a_checker (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I),
   .WORD_VALID_I(WORD_VALID_I), .BYTE_EN_O(BYTE_EN_O), .DATA_VALID_O(DATA_VALID_O),
   .PACKET_START_O(PACKET_START_O), .PACKET_END_O(PACKET_END_O), .BUFFER_LOADED_FLAG_O(BUFFER_LOADED_FLAG_O),
   .TRANSMIT_ERROR_FLAG_O(TRANSMIT_ERROR_FLAG_O), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O));
